/* File: hdl/asid_pkg.sv */
// Constants and types of the serial audio input deframer
// What this block does
// - Accept left-justified, I2S or right-justified words of 16, 18, 20 or 24 bits.
// - Right- and left-justified: word clock high is left, low is right.
// - Right-justified: first bit 12 periods (20-bit) or 16 periods (16-bit) after transition.
// - I2S, the default: word clock low is left, high is right.
// - I2S: first bit one bit-clock period after the word-clock transition.
// - Left-justified: first bit in the same period as the transition.
// - Data and word clock are captured on the rising bit-clock edge.
package asid_pkg;
    localparam int unsigned     ASID_SYNC_STAGES = 2;
    localparam int unsigned     ASID_PIN_COUNT   = 3;
    localparam int unsigned     ASID_MAX_W       = 24;
    localparam logic [5:0]      ASID_MAX_W6      = 6'h18;
    localparam logic [5:0]      ASID_HALF_BITS   = 6'h20;
    localparam logic [5:0]      ASID_POS_MAX     = 6'h3f;
    localparam logic [5:0]      ASID_LJ_DELAY    = 6'h00;
    localparam logic [5:0]      ASID_I2S_DELAY   = 6'h01;
    localparam logic [1:0]      ASID_FMT_I2S     = 2'h0;
    localparam logic [1:0]      ASID_FMT_LJ      = 2'h1;
    localparam logic [1:0]      ASID_FMT_RJ      = 2'h2;
    localparam logic [1:0]      ASID_W16         = 2'h0;
    localparam logic [1:0]      ASID_W18         = 2'h1;
    localparam logic [1:0]      ASID_W20         = 2'h2;
    localparam logic [1:0]      ASID_W24         = 2'h3;
    localparam logic [5:0]      ASID_BITS16      = 6'h10;
    localparam logic [5:0]      ASID_BITS18      = 6'h12;
    localparam logic [5:0]      ASID_BITS20      = 6'h14;
    localparam logic [5:0]      ASID_BITS24      = 6'h18;
    localparam logic [23:0]     ASID_SAMPLE_RST  = 24'h000000;

    typedef enum logic [2:0] {
        ASID_WAIT = 3'b001,
        ASID_SEEN = 3'b010,
        ASID_RUN  = 3'b100
    } asid_state_type;

    function automatic logic [5:0] asid_width_bits(input logic [1:0] code);
        logic [5:0] bits;
        case (code)
            ASID_W16: bits = ASID_BITS16;
            ASID_W18: bits = ASID_BITS18;
            ASID_W20: bits = ASID_BITS20;
            default:  bits = ASID_BITS24;
        endcase
        return bits;
    endfunction : asid_width_bits
endpackage : asid_pkg

/* File: hdl/asid_sync.sv */
// Two-stage synchroniser for the serial audio pins
module asid_sync
    import asid_pkg::*;
#(
    parameter int unsigned WIDTH = ASID_PIN_COUNT
) (
    input  wire logic             sys_clk_i,  // System clock
    input  wire logic             reset_i,    // Synchronous reset, high
    input  wire logic [WIDTH-1:0] async_i,    // Pins from outside the domain
    output logic      [WIDTH-1:0] sync_o      // Pins after two flops
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_sync;

    always_comb begin
        next_meta = async_i;
        next_sync = meta;
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            meta   <= '0;
            sync_o <= '0;
        end else begin
            meta   <= next_meta;
            sync_o <= next_sync;
        end
    end
endmodule : asid_sync

/* File: hdl/asid_deframer.sv */
// Serial audio input deframer: bit clock, word clock and data to sample words
module asid_deframer
    import asid_pkg::*;
(
    input  wire logic        sys_clk_i,       // System clock, 100 MHz
    input  wire logic        reset_i,         // Synchronous reset, high
    input  wire logic        bit_clk_i,       // Serial bit clock pin
    input  wire logic        word_clk_i,      // Left/right word clock pin
    input  wire logic        ser_data_i,      // Serial data pin
    input  wire logic [1:0]  format_i,        // Framing select
    input  wire logic [1:0]  width_i,         // Word width select
    output logic      [23:0] sample_o,        // Received word, MSB at bit 23
    output logic             left_chan_o,     // Word belongs to left channel
    output logic             sample_valid_o,  // One-cycle word strobe
    output logic             locked_o         // Framing found
);
    logic [2:0]     pins_s;
    logic           bclk_prev;
    logic           wclk_last;
    logic           half_lvl;
    logic [5:0]     pos;
    logic [23:0]    shift;
    asid_state_type state;

    logic           next_bclk_prev;
    logic           next_wclk_last;
    logic           next_half_lvl;
    logic [5:0]     next_pos;
    logic [23:0]    next_shift;
    asid_state_type next_state;
    logic [23:0]    next_sample;
    logic           next_left;
    logic           next_valid;
    logic           next_locked;

    logic           rise;
    logic           edge_w;
    logic           lvl;
    logic [5:0]     wbits;
    logic [5:0]     delay;
    logic [5:0]     cur_pos;
    logic           in_word;
    logic           first_bit;
    logic           last_bit;
    logic [23:0]    shifted;

    asid_sync #(
        .WIDTH (ASID_PIN_COUNT)
    ) u_sync (
        .sys_clk_i (sys_clk_i),
        .reset_i   (reset_i),
        .async_i   ({bit_clk_i, word_clk_i, ser_data_i}),
        .sync_o    (pins_s)
    );

    always_comb begin
        wbits = asid_width_bits(width_i);
        if (format_i == ASID_FMT_LJ) begin
            delay = ASID_LJ_DELAY;
        end else if (format_i == ASID_FMT_RJ) begin
            delay = ASID_HALF_BITS - wbits;
        end else begin
            delay = ASID_I2S_DELAY;
        end
    end

    always_comb begin
        next_bclk_prev = pins_s[2];
        next_wclk_last = wclk_last;
        next_half_lvl  = half_lvl;
        next_pos       = pos;
        next_shift     = shift;
        next_state     = state;
        next_sample    = sample_o;
        next_left      = left_chan_o;
        next_valid     = 1'b0;
        rise           = pins_s[2] & ~bclk_prev;
        edge_w         = 1'b0;
        lvl            = half_lvl;
        cur_pos        = pos;
        in_word        = 1'b0;
        first_bit      = 1'b0;
        last_bit       = 1'b0;
        shifted        = {shift[22:0], pins_s[0]};
        if (rise) begin
            next_wclk_last = pins_s[1];
            case (state)
                ASID_WAIT: begin
                    next_state = ASID_SEEN;
                end
                default: begin
                    edge_w = (pins_s[1] != wclk_last);
                    if (edge_w) begin
                        cur_pos       = 6'h00;
                        lvl           = pins_s[1];
                        next_half_lvl = pins_s[1];
                        next_state    = ASID_RUN;
                    end else if (pos != ASID_POS_MAX) begin
                        cur_pos = pos + 6'h01;
                    end
                    next_pos = cur_pos;
                    if (edge_w || state == ASID_RUN) begin
                        in_word = (cur_pos >= delay) && (cur_pos < delay + wbits);
                    end
                    if (in_word) begin
                        next_shift = shifted;
                        first_bit  = (cur_pos == delay);
                        last_bit   = (cur_pos == delay + wbits - 6'h01);
                    end
                    if (last_bit) begin
                        next_sample = shifted << (ASID_MAX_W6 - wbits);
                        next_valid  = 1'b1;
                        if (format_i == ASID_FMT_LJ || format_i == ASID_FMT_RJ) begin
                            next_left = lvl;
                        // I2S and code 3 low is left
                        end else begin
                            next_left = ~lvl;
                        end
                    end
                end
            endcase
        end
        next_locked    = (next_state == ASID_RUN);
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            bclk_prev      <= 1'b0;
            wclk_last      <= 1'b0;
            half_lvl       <= 1'b0;
            pos            <= 6'h00;
            shift          <= ASID_SAMPLE_RST;
            state          <= ASID_WAIT;
            sample_o       <= ASID_SAMPLE_RST;
            left_chan_o    <= 1'b0;
            sample_valid_o <= 1'b0;
            locked_o       <= 1'b0;
        end else begin
            bclk_prev      <= next_bclk_prev;
            wclk_last      <= next_wclk_last;
            half_lvl       <= next_half_lvl;
            pos            <= next_pos;
            shift          <= next_shift;
            state          <= next_state;
            sample_o       <= next_sample;
            left_chan_o    <= next_left;
            sample_valid_o <= next_valid;
            locked_o       <= next_locked;
        end
    end

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (reset_i);

    valid_pulse_a: assert property (sample_valid_o |-> locked_o ##1 !sample_valid_o)
        else $error("word strobe not a single locked pulse");
    sample_hold_a: assert property (
        !sample_valid_o |-> $stable({sample_o, left_chan_o}))
        else $error("received word changed without a strobe");
    low_zero_a: assert property (
        sample_valid_o |-> (sample_o << asid_width_bits(width_i)) == ASID_SAMPLE_RST)
        else $error("unused low bits of the word not zero");
    chan_just_a: assert property (
        next_valid && (format_i == ASID_FMT_LJ || format_i == ASID_FMT_RJ)
        |=> left_chan_o == $past(lvl))
        else $error("justified channel level wrong");
    rj_fixed_a: assert property (
        first_bit && format_i == ASID_FMT_RJ && width_i == ASID_W20 |-> cur_pos == 6'h0c)
        else $error("right-justified 20-bit start wrong");
    rj_short_a: assert property (
        first_bit && format_i == ASID_FMT_RJ && width_i == ASID_W16 |-> cur_pos == 6'h10)
        else $error("right-justified 16-bit start wrong");
    chan_i2s_a: assert property (
        next_valid && format_i != ASID_FMT_LJ && format_i != ASID_FMT_RJ
        |=> left_chan_o == !$past(lvl))
        else $error("I2S channel level wrong");
    i2s_start_a: assert property (
        first_bit && format_i == ASID_FMT_I2S |-> cur_pos == 6'h01)
        else $error("I2S first bit not one period late");
    i2s_end_a: assert property (
        last_bit && format_i == ASID_FMT_I2S && width_i == ASID_W24 |-> cur_pos == 6'h18)
        else $error("I2S 24-bit last bit misplaced");
    lj_start_a: assert property (
        first_bit && format_i == ASID_FMT_LJ |-> cur_pos == 6'h00)
        else $error("left-justified first bit delayed");
    rise_capture_a: assert property ($changed(shift) |-> $past(rise))
        else $error("data taken off the rising bit-clock edge");
    rj_general_a: assert property (
        last_bit && format_i == ASID_FMT_RJ |-> cur_pos == 6'h1f)
        else $error("right-justified last bit not before transition");
    rj_wide_a: assert property (
        first_bit && format_i == ASID_FMT_RJ && width_i == ASID_W24 |-> cur_pos == 6'h08)
        else $error("right-justified 24-bit start wrong");
    rj_mid_a: assert property (
        first_bit && format_i == ASID_FMT_RJ && width_i == ASID_W18 |-> cur_pos == 6'h0e)
        else $error("right-justified 18-bit start wrong");

    left_word_c: cover property (sample_valid_o && left_chan_o);
    right_word_c: cover property (sample_valid_o && !left_chan_o);
    rj24_word_c: cover property (
        next_valid && format_i == ASID_FMT_RJ && width_i == ASID_W24);
    lj_word_c: cover property (
        next_valid && format_i == ASID_FMT_LJ);
    i2s_word_c: cover property (
        next_valid && format_i == ASID_FMT_I2S);
endmodule : asid_deframer

/* File: verif/asid_src_model.sv */
// Serial audio source model: bit clock, word clock and data
module asid_src_model
    import asid_pkg::*;
(
    input  wire logic sys_clk_i,   // Pacing clock
    output logic      bit_clk_o,   // Bit clock, still between frames
    output logic      word_clk_o,  // Word clock
    output logic      data_o       // Serial data
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        bit_clk_o  = 1'b0;
        word_clk_o = 1'b1;
        data_o     = 1'b0;
    end

    task automatic bit_slot(input logic wc, input logic d);
        bit_clk_o  = 1'b0;
        word_clk_o = wc;
        data_o     = d;
        repeat (8) @(negedge sys_clk_i);
        bit_clk_o = 1'b1;
        repeat (8) @(negedge sys_clk_i);
    endtask : bit_slot

    task automatic send_half(input logic [1:0] fmt, input int n, input logic left,
                             input logic [23:0] word);
        int   first;
        logic wc;
        first = (fmt == ASID_FMT_LJ) ? 0 : (fmt == ASID_FMT_RJ) ? 32 - n : 1;
        wc = (fmt == ASID_FMT_LJ || fmt == ASID_FMT_RJ) ? left : !left;
        for (int p = 0; p < 32; p++) begin
            bit_slot(wc, (p >= first && p < first + n) ? word[n-1-(p-first)] : !data_o);
        end
    endtask : send_half

    task automatic send_frame(input logic [1:0] fmt, input int n, input logic [23:0] lw,
                              input logic [23:0] rw);
        bit_slot((fmt == ASID_FMT_LJ || fmt == ASID_FMT_RJ) ? 1'b0 : 1'b1, !data_o);
        send_half(fmt, n, 1'b1, lw);
        send_half(fmt, n, 1'b0, rw);
        bit_clk_o = 1'b0;
        data_o    = !data_o;
        @(negedge sys_clk_i);
    endtask : send_frame
endmodule : asid_src_model

/* File: verif/audio_serial_input_deframer_tb_top.sv */
// Self-checking bench of the serial audio input deframer
module audio_serial_input_deframer_tb_top
    import asid_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [1:0]  fmt;
        logic [1:0]  wid;
        logic [23:0] lw;
        logic [23:0] rw;
    } asid_row_type;

    asid_row_type rows [9] = '{
        '{2'h0, 2'h0, 24'h00a5c3, 24'h003c5a}, '{2'h0, 2'h3, 24'h81f00e, 24'h7e0ff1},
        '{2'h1, 2'h1, 24'h02d1b4, 24'h012e4b}, '{2'h1, 2'h2, 24'h080001, 24'h07fffe},
        '{2'h2, 2'h0, 24'h008421, 24'h007bde}, '{2'h2, 2'h1, 24'h03ffff, 24'h000001},
        '{2'h2, 2'h2, 24'h0c0f0a, 24'h03f0f5}, '{2'h2, 2'h3, 24'hf00001, 24'h0ffffe},
        '{2'h3, 2'h2, 24'h012345, 24'h0edcba}};

    logic        sys_clk = 1'b0;
    logic        reset   = 1'b1;
    logic        bit_clk, word_clk, ser_data;
    logic [1:0]  format  = 2'h0;
    logic [1:0]  width   = 2'h0;
    logic [23:0] sample;
    logic        left_chan, sample_valid, locked;
    logic [24:0] got_q [$];
    int          fail_count = 0;
    int          tests_run  = 0;

    always #5 sys_clk = ~sys_clk;

    asid_src_model u_src (.sys_clk_i(sys_clk), .bit_clk_o(bit_clk), .word_clk_o(word_clk),
                          .data_o(ser_data));

    asid_deframer u_dut (.sys_clk_i(sys_clk), .reset_i(reset), .bit_clk_i(bit_clk),
        .word_clk_i(word_clk), .ser_data_i(ser_data), .format_i(format), .width_i(width),
        .sample_o(sample), .left_chan_o(left_chan), .sample_valid_o(sample_valid),
        .locked_o(locked));

    always @(negedge sys_clk) if (sample_valid === 1'b1) got_q.push_back({left_chan, sample});

    task automatic chk(input string name, input logic [24:0] exp, input logic [24:0] got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : report_and_stop

    task automatic do_reset(input logic [1:0] fmt, input logic [1:0] wid);
        @(negedge sys_clk);
        reset  = 1'b1;
        format = fmt;
        width  = wid;
        repeat (2) @(negedge sys_clk);
        chk("reset_outputs", 25'h0, {left_chan, sample});
        chk("reset_flags", 25'h0, {23'h0, sample_valid, locked});
        reset = 1'b0;
        @(negedge sys_clk);
        chk("release_outputs", 25'h0, {left_chan, sample});
        chk("release_flags", 25'h0, {23'h0, sample_valid, locked});
        got_q.delete();
    endtask : do_reset

    // Frames of one row, then every word compared
    task automatic run_row(input asid_row_type r, input int frames);
        int n;
        n = (r.wid == 2'h0) ? 16 : (r.wid == 2'h1) ? 18 : (r.wid == 2'h2) ? 20 : 24;
        do_reset(r.fmt, r.wid);
        for (int f = 0; f < frames; f++) u_src.send_frame(r.fmt, n, r.lw, r.rw);
        repeat (8) @(negedge sys_clk);
        chk("word_count", 25'(2 * frames), 25'(got_q.size()));
        chk("locked", 25'h1, {24'h0, locked});
        for (int i = 0; i < 2 * frames; i++) begin
            chk("word", {i % 2 == 0, (i % 2 == 0 ? r.lw : r.rw) << (24 - n)},
                (got_q.size() > i) ? got_q[i] : 25'hx);
        end
    endtask : run_row

    initial begin
        repeat (2) @(negedge sys_clk);
        foreach (rows[i]) run_row(rows[i], 1);
        // Back-to-back frames, I2S 24-bit
        run_row(rows[1], 2);
        // No word-clock transition yet: no lock, no words
        do_reset(2'h0, 2'h0);
        for (int i = 0; i < 40; i++) u_src.bit_slot(word_clk, i[0]);
        repeat (8) @(negedge sys_clk);
        chk("idle_lock", 25'h0, {24'h0, locked});
        chk("idle_words", 25'h0, 25'(got_q.size()));
        report_and_stop();
    end

    initial begin
        #500000;
        fail_count++;
        report_and_stop();
    end
endmodule : audio_serial_input_deframer_tb_top
